// >>> pkg/pin_wake_pkg.sv
// package: register map, field positions and carrier types of the pin wake unit
// assumes an 8-bit register port with one-cycle read latency
// Overview of operation
// - eight enable bits; only enabled inputs detect and raise the flag
// - polarity bit per input: 0 falling/low, 1 rising/high
// - control bit 0 picks edge-only (0) or edge-and-level (1)
// - flag at bit 3 set by detection, software writes to bit 3 leave it alone
// - writing 1 to bit 2 acknowledges the flag; bit 2 reads zero
// - request asserted only while flag set and enable bit 1 was set the cycle before
// - falling edge: sampled 1 then 0 on consecutive bus cycles
// - rising edge: sampled 0 then 1 on consecutive bus cycles
// - edge needs input first seen deasserted; asserted-at-enable gives no edge
// - in stop, enabled inputs bypass the edge detector as async level wakes
// - keeps working in wait; enabled input with enable set wakes from wait
// - wakes from stop through enabled input if configured before stop
// - normal operation continues in background debug mode
// - level mode: acknowledge leaves flag set while any enabled input asserted
// - edge mode: flag set on edge, cleared by acknowledge unless an edge arrives in the same cycle
package pin_wake_pkg;
   localparam int          NUM_INPUTS     = 8;
   localparam int          ADDR_W         = 4;
   // register offsets
   localparam logic [3:0]  OFS_STATUS_CTL = 4'h0;
   localparam logic [3:0]  OFS_PIN_EN     = 4'h1;
   localparam logic [3:0]  OFS_POLARITY   = 4'h2;
   localparam logic [3:0]  OFS_IRQ_STAT   = 4'h3;
   localparam logic [3:0]  OFS_IRQ_MASK   = 4'h4;
   // status/control fields
   localparam int          BIT_MODE       = 0;
   localparam int          BIT_IRQ_EN     = 1;
   localparam int          BIT_ACK        = 2;
   localparam int          BIT_FLAG       = 3;
   // sticky event bits
   localparam int          EV_DETECT      = 0;
   localparam int          EV_ACK_HELD    = 1;
   localparam logic [7:0]  RESET_BYTE     = 8'h00;
   localparam logic [1:0]  RESET_EV       = 2'h0;

   typedef struct packed {
      logic             wr;
      logic             rd;
      logic [3:0]       addr;
      logic [7:0]       wdata;
   } reg_req_s;

   typedef struct packed {
      logic [7:0]       enables;
      logic [7:0]       polarity;
      logic             levelMode;
   } wake_cfg_s;
endpackage

// >>> hw/pin_sync.sv
// pin_sync: three-flop synchroniser per wake input, change taken when flops two and three agree
// assumes pins are asynchronous to clk
`timescale 1ns/10ps
module pin_sync (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // pins
   input  wire logic [7:0]  pinsIn,
   // filtered level
   output logic [7:0]       pinsOut
);
   logic [7:0] s1_r;
   logic [7:0] s2_r;
   logic [7:0] s3_r;
   logic [7:0] held_r;
   logic [7:0] held_nxt;

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         assign held_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : held_r[i];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r   <= pin_wake_pkg::RESET_BYTE;
         s2_r   <= pin_wake_pkg::RESET_BYTE;
         s3_r   <= pin_wake_pkg::RESET_BYTE;
         held_r <= pin_wake_pkg::RESET_BYTE;
      end else begin
         s1_r   <= pinsIn;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         held_r <= held_nxt;
      end
   end

   assign pinsOut = held_r;
endmodule // pin_sync

// >>> hw/edge_level_detect.sv
// edge_level_detect: per-input assertion, edge and level detection
// assumes synchronised inputs on clk
`timescale 1ns/10ps
module edge_level_detect (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // configuration and inputs
   input  wire pin_wake_pkg::wake_cfg_s cfg,
   input  wire logic [7:0]             level,
   // results
   output logic [7:0]                  asserted,
   output logic [7:0]                  edgeHit
);
   logic [7:0] prevAsserted_r;
   logic [7:0] prevEn_r;

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_in
         // active sense by polarity
         assign asserted[i] = cfg.enables[i] & (level[i] == cfg.polarity[i]);
         // edge: deasserted last cycle while enabled, asserted now
         assign edgeHit[i]  = asserted[i] & prevEn_r[i] & ~prevAsserted_r[i];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         prevAsserted_r <= pin_wake_pkg::RESET_BYTE;
         prevEn_r       <= pin_wake_pkg::RESET_BYTE;
      end else begin
         prevAsserted_r <= asserted;
         prevEn_r       <= cfg.enables;
      end
   end
endmodule // edge_level_detect

// >>> hw/pin_wake_interrupt.sv
// pin_wake_interrupt: eight-input wake and interrupt unit with register port
// assumes one clock; stopMode high means clocks are halted (async wake path)
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
module pin_wake_interrupt (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register port
   input  wire logic [3:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [7:0]       regRdata,
   // pins and modes
   input  wire logic [7:0]  wakeInputPin,
   input  wire logic        stopMode,
   // processor side
   output logic             wakeIrq,
   output logic             eventIrq,
   output logic             stopWake
);
   pin_wake_pkg::reg_req_s  req;
   pin_wake_pkg::wake_cfg_s cfg;
   logic [7:0] pinEn_r;
   logic [7:0] polarity_r;
   logic       modeLevel_r;
   logic       irqEn_r;
   logic       flag_r;
   logic       flag_nxt;
   logic [1:0] evStat_r;
   logic [1:0] evStat_nxt;
   logic [1:0] evMask_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       wakeIrq_r;
   logic       eventIrq_r;
   logic       stopWake_r;
   logic [7:0] syncLevel;
   logic [7:0] asserted;
   logic [7:0] edgeHit;
   logic [7:0] asyncAsserted;

   assign req = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};
   assign cfg = '{enables: pinEn_r, polarity: polarity_r, levelMode: modeLevel_r};

   pin_sync u_sync (
      .clk     (clk),
      .rst     (rst),
      .pinsIn  (wakeInputPin),
      .pinsOut (syncLevel)
   );

   edge_level_detect u_detect (
      .clk      (clk),
      .rst      (rst),
      .cfg      (cfg),
      .level    (syncLevel),
      .asserted (asserted),
      .edgeHit  (edgeHit)
   );

   // address decode
   wire wrCtl   = req.wr && (req.addr == pin_wake_pkg::OFS_STATUS_CTL);
   wire wrEn    = req.wr && (req.addr == pin_wake_pkg::OFS_PIN_EN);
   wire wrPol   = req.wr && (req.addr == pin_wake_pkg::OFS_POLARITY);
   wire wrStat  = req.wr && (req.addr == pin_wake_pkg::OFS_IRQ_STAT);
   wire wrMask  = req.wr && (req.addr == pin_wake_pkg::OFS_IRQ_MASK);
   wire ackWr   = wrCtl && req.wdata[pin_wake_pkg::BIT_ACK];

   // detection: edges always, levels too in level mode
   wire anyEdge     = |edgeHit;
   wire anyAsserted = |asserted;
   wire detect      = anyEdge | (modeLevel_r & anyAsserted);
   // acknowledge blocked by a held level in level mode
   wire ackBlocked  = modeLevel_r & anyAsserted;
   wire ackClears   = ackWr & ~ackBlocked;

   // set wins over clear; writes never load the flag directly
   assign flag_nxt = detect ? 1'b1 : (ackClears ? 1'b0 : flag_r);

   // sticky event bits, write one to clear, set wins
   wire [1:0] evSet = {ackWr & ackBlocked, detect};
   assign evStat_nxt = evSet | (evStat_r & ~(wrStat ? req.wdata[1:0] : 2'h0));

   // async stop-mode level path: pin compared with polarity, no clock involved
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_async
         assign asyncAsserted[i] = pinEn_r[i] & (wakeInputPin[i] == polarity_r[i]);
      end
   endgenerate

   // read mux
   always_comb begin
      rdata_nxt = pin_wake_pkg::RESET_BYTE;
      if (req.rd) begin
         unique case (req.addr)
            pin_wake_pkg::OFS_STATUS_CTL: begin
               rdata_nxt[pin_wake_pkg::BIT_FLAG]   = flag_r;
               rdata_nxt[pin_wake_pkg::BIT_IRQ_EN] = irqEn_r;
               rdata_nxt[pin_wake_pkg::BIT_MODE]   = modeLevel_r;
            end
            pin_wake_pkg::OFS_PIN_EN:   rdata_nxt = pinEn_r;
            pin_wake_pkg::OFS_POLARITY: rdata_nxt = polarity_r;
            pin_wake_pkg::OFS_IRQ_STAT: rdata_nxt[1:0] = evStat_r;
            pin_wake_pkg::OFS_IRQ_MASK: rdata_nxt[1:0] = evMask_r;
            default:                    rdata_nxt = pin_wake_pkg::RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pinEn_r     <= pin_wake_pkg::RESET_BYTE;
         polarity_r  <= pin_wake_pkg::RESET_BYTE;
         modeLevel_r <= 1'b0;
         irqEn_r     <= 1'b0;
         flag_r      <= 1'b0;
         evStat_r    <= pin_wake_pkg::RESET_EV;
         evMask_r    <= pin_wake_pkg::RESET_EV;
         rdata_r     <= pin_wake_pkg::RESET_BYTE;
      end else begin
         if (wrEn) pinEn_r <= req.wdata;
         if (wrPol) polarity_r <= req.wdata;
         if (wrCtl) begin
            modeLevel_r <= req.wdata[pin_wake_pkg::BIT_MODE];
            irqEn_r     <= req.wdata[pin_wake_pkg::BIT_IRQ_EN];
         end
         if (wrMask) evMask_r <= req.wdata[1:0];
         flag_r   <= flag_nxt;
         evStat_r <= evStat_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // registered outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         wakeIrq_r  <= 1'b0;
         eventIrq_r <= 1'b0;
         stopWake_r <= 1'b0;
      end else begin
         wakeIrq_r  <= flag_nxt & irqEn_r;
         eventIrq_r <= |(evStat_nxt & evMask_r);
         stopWake_r <= stopMode & irqEn_r & (|asyncAsserted);
      end
   end

   assign regRdata = rdata_r;
   assign wakeIrq  = wakeIrq_r;
   assign eventIrq = eventIrq_r;
   assign stopWake = stopWake_r;

   // assertions
   ack_reads_zero_a: assert property (@(posedge clk) disable iff (rst)
      regRd && regAddr == pin_wake_pkg::OFS_STATUS_CTL |=> !regRdata[pin_wake_pkg::BIT_ACK])
      else $error("acknowledge bit read back nonzero");
   irq_needs_enable_a: assert property (@(posedge clk) disable iff (rst)
      wakeIrq |-> $past(irqEn_r))
      else $error("request without interrupt enable");
   irq_follows_flag_a: assert property (@(posedge clk) disable iff (rst)
      flag_r && irqEn_r |=> wakeIrq || $past(ackClears))
      else $error("flag and enable set but no request");
   same_cycle_keep_a: assert property (@(posedge clk) disable iff (rst)
      detect && ackWr |=> flag_r)
      else $error("event lost at acknowledge");
   level_hold_a: assert property (@(posedge clk) disable iff (rst)
      ackWr && modeLevel_r && anyAsserted |=> flag_r)
      else $error("flag cleared while input asserted");
   edge_clear_a: assert property (@(posedge clk) disable iff (rst)
      ackWr && !modeLevel_r && !anyEdge |=> !flag_r)
      else $error("edge mode acknowledge did not clear");
   edge_sets_a: assert property (@(posedge clk) disable iff (rst)
      anyEdge |=> flag_r ##1 (flag_r || $past(ackClears)))
      else $error("edge did not set flag");
   write_no_flag_a: assert property (@(posedge clk) disable iff (rst)
      !flag_r && wrCtl && !detect |=> !flag_r)
      else $error("write changed flag");
   disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
      (pinEn_r == pin_wake_pkg::RESET_BYTE) && !flag_r |=> !flag_r)
      else $error("flag set with no enabled input");
   stop_wake_a: assert property (@(posedge clk) disable iff (rst)
      stopMode && irqEn_r && (|asyncAsserted) |=> stopWake)
      else $error("stop wake missing");

   // reset clears every control bit and output
   reset_regs_a: assert property (@(posedge clk)
      rst |=> pinEn_r == pin_wake_pkg::RESET_BYTE && polarity_r == pin_wake_pkg::RESET_BYTE)
      else $error("enables or polarities survived reset");
   reset_ctl_a: assert property (@(posedge clk)
      rst |=> !modeLevel_r && !irqEn_r && !flag_r)
      else $error("mode, enable or flag survived reset");
   reset_outputs_a: assert property (@(posedge clk)
      rst |=> !wakeIrq && !eventIrq && !stopWake && regRdata == pin_wake_pkg::RESET_BYTE)
      else $error("output high after reset");
   reset_events_a: assert property (@(posedge clk)
      rst |=> evStat_r == pin_wake_pkg::RESET_EV && evMask_r == pin_wake_pkg::RESET_EV)
      else $error("event bits survived reset");

   // register port reads and writes
   read_enables_a: assert property (@(posedge clk) disable iff (rst)
      regRd && regAddr == pin_wake_pkg::OFS_PIN_EN |=> regRdata == $past(pinEn_r))
      else $error("enable register read back wrong");
   read_polarity_a: assert property (@(posedge clk) disable iff (rst)
      regRd && regAddr == pin_wake_pkg::OFS_POLARITY |=> regRdata == $past(polarity_r))
      else $error("polarity register read back wrong");
   read_flag_a: assert property (@(posedge clk) disable iff (rst)
      regRd && regAddr == pin_wake_pkg::OFS_STATUS_CTL |=> regRdata[pin_wake_pkg::BIT_FLAG] == $past(flag_r))
      else $error("flag read back wrong");
   read_mode_a: assert property (@(posedge clk) disable iff (rst)
      regRd && regAddr == pin_wake_pkg::OFS_STATUS_CTL |=> regRdata[pin_wake_pkg::BIT_MODE] == $past(modeLevel_r))
      else $error("mode bit read back wrong");
   read_irq_en_a: assert property (@(posedge clk) disable iff (rst)
      regRd && regAddr == pin_wake_pkg::OFS_STATUS_CTL |=> regRdata[pin_wake_pkg::BIT_IRQ_EN] == $past(irqEn_r))
      else $error("interrupt enable read back wrong");
   read_upper_zero_a: assert property (@(posedge clk) disable iff (rst)
      regRd && regAddr == pin_wake_pkg::OFS_STATUS_CTL |=> regRdata[7:4] == 4'h0)
      else $error("unused status bits read nonzero");
   read_events_a: assert property (@(posedge clk) disable iff (rst)
      regRd && regAddr == pin_wake_pkg::OFS_IRQ_STAT |=> regRdata[1:0] == $past(evStat_r))
      else $error("event bits read back wrong");
   write_enables_a: assert property (@(posedge clk) disable iff (rst)
      wrEn |=> pinEn_r == $past(regWdata))
      else $error("enable write did not land");
   write_polarity_a: assert property (@(posedge clk) disable iff (rst)
      wrPol |=> polarity_r == $past(regWdata))
      else $error("polarity write did not land");
   write_mode_a: assert property (@(posedge clk) disable iff (rst)
      wrCtl |=> modeLevel_r == $past(regWdata[pin_wake_pkg::BIT_MODE]))
      else $error("mode write did not land");
   write_irq_en_a: assert property (@(posedge clk) disable iff (rst)
      wrCtl |=> irqEn_r == $past(regWdata[pin_wake_pkg::BIT_IRQ_EN]))
      else $error("interrupt enable write did not land");
   enables_hold_a: assert property (@(posedge clk) disable iff (rst)
      !wrEn |=> $stable(pinEn_r))
      else $error("enables changed without a write");
   polarity_hold_a: assert property (@(posedge clk) disable iff (rst)
      !wrPol |=> $stable(polarity_r))
      else $error("polarities changed without a write");

   // flag set and clear
   flag_needs_cause_a: assert property (@(posedge clk) disable iff (rst)
      !flag_r && !detect |=> !flag_r)
      else $error("flag set with no detection");
   flag_bit_write_a: assert property (@(posedge clk) disable iff (rst)
      wrCtl && regWdata[pin_wake_pkg::BIT_FLAG] && !flag_r && !detect |=> !flag_r)
      else $error("write of one set the flag");
   flag_needs_ack_a: assert property (@(posedge clk) disable iff (rst)
      flag_r && !ackWr |=> flag_r)
      else $error("flag cleared without acknowledge");
   edge_mode_held_a: assert property (@(posedge clk) disable iff (rst)
      !modeLevel_r && anyAsserted && !anyEdge && ackWr |=> !flag_r)
      else $error("edge mode acknowledge blocked by level");
   level_sets_a: assert property (@(posedge clk) disable iff (rst)
      modeLevel_r && anyAsserted |=> flag_r)
      else $error("asserted level did not set flag");
   event_set_a: assert property (@(posedge clk) disable iff (rst)
      detect |=> evStat_r[pin_wake_pkg::EV_DETECT])
      else $error("detection event bit not set");
   same_cycle_event_a: assert property (@(posedge clk) disable iff (rst)
      detect && ackWr |=> evStat_r[pin_wake_pkg::EV_DETECT])
      else $error("detection event lost at acknowledge");
   ack_held_event_a: assert property (@(posedge clk) disable iff (rst)
      ackWr && ackBlocked |=> evStat_r[pin_wake_pkg::EV_ACK_HELD])
      else $error("refused acknowledge not recorded");
   ack_held_clear_a: assert property (@(posedge clk) disable iff (rst)
      wrStat && regWdata[pin_wake_pkg::EV_ACK_HELD] |=> !evStat_r[pin_wake_pkg::EV_ACK_HELD])
      else $error("refused acknowledge bit not cleared");

   // edge detector
   edge_enabled_a: assert property (@(posedge clk) disable iff (rst)
      (edgeHit & ~pinEn_r) == pin_wake_pkg::RESET_BYTE)
      else $error("edge on a disabled input");
   edge_was_enabled_a: assert property (@(posedge clk) disable iff (rst)
      (edgeHit & ~$past(pinEn_r)) == pin_wake_pkg::RESET_BYTE)
      else $error("edge on an input enabled this cycle");
   edge_was_idle_a: assert property (@(posedge clk) disable iff (rst)
      (edgeHit & $past(asserted)) == pin_wake_pkg::RESET_BYTE)
      else $error("edge on an input already asserted");
   edge_falling_a: assert property (@(posedge clk) disable iff (rst)
      $stable(polarity_r) |-> (edgeHit & ~polarity_r & ~$past(syncLevel)) == pin_wake_pkg::RESET_BYTE)
      else $error("falling edge without prior high sample");
   edge_rising_a: assert property (@(posedge clk) disable iff (rst)
      $stable(polarity_r) |-> (edgeHit & polarity_r & $past(syncLevel)) == pin_wake_pkg::RESET_BYTE)
      else $error("rising edge without prior low sample");

   // interrupt outputs
   irq_masked_a: assert property (@(posedge clk) disable iff (rst)
      !irqEn_r |=> !wakeIrq)
      else $error("request while interrupt enable clear");
   irq_has_flag_a: assert property (@(posedge clk) disable iff (rst)
      wakeIrq |-> flag_r)
      else $error("request without flag");
   irq_after_enable_a: assert property (@(posedge clk) disable iff (rst)
      flag_r && $rose(irqEn_r) |=> wakeIrq || $past(ackClears))
      else $error("pending flag not requested after enable");
   event_irq_src_a: assert property (@(posedge clk) disable iff (rst)
      eventIrq |-> (evStat_r & $past(evMask_r)) != pin_wake_pkg::RESET_EV)
      else $error("event interrupt without unmasked event");

   // stop-mode wake path
   stop_only_a: assert property (@(posedge clk) disable iff (rst)
      !stopMode |=> !stopWake)
      else $error("stop wake outside stop mode");
   stop_needs_irq_en_a: assert property (@(posedge clk) disable iff (rst)
      !irqEn_r |=> !stopWake)
      else $error("stop wake with interrupt enable clear");
   stop_needs_pin_a: assert property (@(posedge clk) disable iff (rst)
      (pinEn_r == pin_wake_pkg::RESET_BYTE) |=> !stopWake)
      else $error("stop wake with no enabled input");
endmodule // pin_wake_interrupt

// >>> testbench/pin_switch_model.sv
// pin_switch_model: wake sources on the input pins, prompt or lagging two clocks
// assumes want is driven by the bench just after rising edges of clk
`timescale 1ns/10ps
module pin_switch_model (
   // clock
   input  wire logic       clk,
   // commanded levels and response speed
   input  wire logic [7:0] want,
   input  wire logic       slow,
   // pin levels
   output logic [7:0]      pins
);
   logic [7:0] lag1;
   logic [7:0] lag2;

   // slow sources reach their new level two clocks late
   always_ff @(posedge clk) begin
      lag1 <= want;
      lag2 <= lag1;
   end

   assign pins = slow ? lag2 : want;
endmodule // pin_switch_model

// >>> testbench/test_pin_wake_interrupt.sv
// test_pin_wake_interrupt: self-checking bench for the pin wake unit
// assumes pin_wake_pkg, the design and pin_switch_model compiled first
`timescale 1ns/10ps
module test_pin_wake_interrupt;
   logic        clk      = 1'b0;
   logic        rst      = 1'b1;
   logic [3:0]  regAddr  = 4'h0;
   logic [7:0]  regWdata = 8'h00;
   logic        regWr    = 1'b0;
   logic        regRd    = 1'b0;
   logic [7:0]  want     = 8'h00;
   logic        slow     = 1'b0;
   logic        stopMode = 1'b0;
   logic [7:0]  regRdata;
   logic [7:0]  wakeInputPin;
   logic        wakeIrq;
   logic        eventIrq;
   logic        stopWake;
   logic [31:0] seed     = 32'h783a3d7a;
   logic [7:0]  rv;
   int          miscompares = 0;
   int          nChecks     = 0;
   int          cycles      = 0;

   pin_wake_interrupt dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .wakeInputPin(wakeInputPin), .stopMode(stopMode),
      .wakeIrq(wakeIrq), .eventIrq(eventIrq), .stopWake(stopWake));
   pin_switch_model sw_u (.clk(clk), .want(want), .slow(slow), .pins(wakeInputPin));

   always #20 clk = ~clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   function automatic logic [7:0] scExp(input logic flag, input logic ie, input logic md);
      return {4'h0, flag, 1'b0, ie, md};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      nChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk);
      regWr    <= 1'b1;
      regAddr  <= ad;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] ad);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= ad;
      @(posedge clk);
      regRd <= 1'b0;
      // answer stands until this edge; taken before the edge updates it
      @(posedge clk);
      rv = regRdata;
   endtask

   // new pin levels, then time for the synchroniser and detector
   task automatic pin(input logic [7:0] lv);
      @(posedge clk);
      want <= lv;
      repeat (10) @(posedge clk);
   endtask

   task automatic print_verdict;
      $display("checks=%0d miscompares=%0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(4'(i));
         chk(rv, 8'h00);
      end
      // random config while pins sit still: nothing may be detected
      repeat (8) begin
         seed = xs(seed);
         // disable before repolarising, so only fresh enables are seen
         wr(pin_wake_pkg::OFS_PIN_EN, 8'h00);
         wr(pin_wake_pkg::OFS_POLARITY, seed[15:8]);
         wr(pin_wake_pkg::OFS_PIN_EN, seed[7:0]);
         rd(pin_wake_pkg::OFS_PIN_EN);
         chk(rv, seed[7:0]);
         rd(pin_wake_pkg::OFS_POLARITY);
         chk(rv, seed[15:8]);
      end
      rd(pin_wake_pkg::OFS_STATUS_CTL);
      chk(rv, scExp(1'b0, 1'b0, 1'b0));
      wr(pin_wake_pkg::OFS_PIN_EN, 8'h00);
      repeat (6) begin
         seed = xs(seed);
         pin(seed[7:0]);
      end
      rd(pin_wake_pkg::OFS_STATUS_CTL);
      chk(rv, scExp(1'b0, 1'b0, 1'b0));
      // edge mode, falling then rising, lagging source on falling
      for (int p = 0; p < 2; p++) begin
         slow <= (p == 0);
         pin({8{p == 0}});
         wr(pin_wake_pkg::OFS_STATUS_CTL, 8'h00);
         wr(pin_wake_pkg::OFS_POLARITY, {8{p == 1}});
         wr(pin_wake_pkg::OFS_PIN_EN, 8'h01);
         wr(pin_wake_pkg::OFS_STATUS_CTL, 8'h04);
         wr(pin_wake_pkg::OFS_STATUS_CTL, 8'h02);
         rd(pin_wake_pkg::OFS_STATUS_CTL);
         chk(rv, scExp(1'b0, 1'b1, 1'b0));
         chk({7'h0, wakeIrq}, 8'h00);
         pin({{7{p == 0}}, p == 1});
         rd(pin_wake_pkg::OFS_STATUS_CTL);
         chk(rv, scExp(1'b1, 1'b1, 1'b0));
         chk({7'h0, wakeIrq}, 8'h01);
         wr(pin_wake_pkg::OFS_STATUS_CTL, 8'h00);
         rd(pin_wake_pkg::OFS_STATUS_CTL);
         chk(rv, scExp(1'b1, 1'b0, 1'b0));
         chk({7'h0, wakeIrq}, 8'h00);
         wr(pin_wake_pkg::OFS_STATUS_CTL, 8'h06);
         rd(pin_wake_pkg::OFS_STATUS_CTL);
         chk(rv, scExp(1'b0, 1'b1, 1'b0));
      end
      // level mode with pin held high, sticky events and mask
      slow <= 1'b0;
      pin(8'h00);
      wr(pin_wake_pkg::OFS_POLARITY, 8'h01);
      wr(pin_wake_pkg::OFS_IRQ_STAT, 8'hff);
      wr(pin_wake_pkg::OFS_STATUS_CTL, 8'h07);
      pin(8'h01);
      wr(pin_wake_pkg::OFS_STATUS_CTL, 8'h07);
      rd(pin_wake_pkg::OFS_STATUS_CTL);
      chk(rv, scExp(1'b1, 1'b1, 1'b1));
      rd(pin_wake_pkg::OFS_IRQ_STAT);
      chk(rv, 8'h03);
      chk({7'h0, eventIrq}, 8'h00);
      wr(pin_wake_pkg::OFS_IRQ_MASK, 8'h02);
      rd(pin_wake_pkg::OFS_IRQ_MASK);
      chk(rv, 8'h02);
      chk({7'h0, eventIrq}, 8'h01);
      wr(pin_wake_pkg::OFS_IRQ_STAT, 8'h02);
      rd(pin_wake_pkg::OFS_IRQ_STAT);
      chk(rv, 8'h01);
      chk({7'h0, eventIrq}, 8'h00);
      // stop mode: asserted enabled pin is a level wake request
      stopMode <= 1'b1;
      pin(8'h01);
      chk({7'h0, stopWake}, 8'h01);
      pin(8'h00);
      chk({7'h0, stopWake}, 8'h00);
      stopMode <= 1'b0;
      wr(pin_wake_pkg::OFS_STATUS_CTL, 8'h07);
      rd(pin_wake_pkg::OFS_STATUS_CTL);
      chk(rv, scExp(1'b0, 1'b1, 1'b1));
      // second reset in mid-run: every register back to cleared
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(4'(i));
         chk(rv, 8'h00);
      end
      chk({7'h0, wakeIrq}, 8'h00);
      print_verdict();
   end
endmodule // test_pin_wake_interrupt
